// file: common/adcreg_pkg.sv
package adcreg_pkg;
   // Register offsets (byte addresses, 16-bit registers)
   localparam logic [7:0] SAMPLE_RATE_OFS = 8'h06;
   localparam logic [7:0] IRQ_LEVEL_OFS = 8'h08;
   localparam logic [7:0] VECTOR_OFS = 8'h0A;
   localparam logic [7:0] RESET_CMD_OFS = 8'h0C;
   localparam logic [7:0] TRIGGER_CMD_OFS = 8'h0E;
   localparam logic [7:0] GAIN_RAM_OFS = 8'h10;
   // Field widths and positions
   localparam int RATE_W = 15;
   localparam int LEVEL_W = 3;
   localparam int VECTOR_W = 8;
   localparam int CHAN_W = 6;
   localparam int CHANNELS = 64;
   localparam int GAIN_BIT = 0;
   // Reset values
   localparam logic [14:0] RATE_RST = 15'h0000;
   localparam logic [2:0] LEVEL_RST = 3'h0;
   localparam logic [7:0] VECTOR_RST = 8'h00;
   // Fixed read-back values of unused bits
   localparam logic [15:0] ONES_HIGH = 16'hFF00;
   localparam logic [15:0] UNMAPPED_READ = 16'hFFFF;
   // Rate timing
   localparam logic [14:0] RATE_FLOOR = 15'h007A;
   localparam int RATE_ADD = 3;
   localparam int REF_CLK_HZ = 12_500_000;
   localparam int FIXED_RATE_HZ = 100_000;
   localparam logic [15:0] FIXED_DIV = 16'(REF_CLK_HZ / FIXED_RATE_HZ);
   localparam int SYS_CLK_HZ = 25_000_000;
   localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
   // Calibration pulse length after a board reset
   localparam int CAL_CYCLES = 16;
   localparam logic [4:0] CAL_LEN = 5'(CAL_CYCLES);
   // Access state machine
   typedef enum logic [2:0] {
      ADCREG_IDLE = 3'b001,
      ADCREG_ACK = 3'b010,
      ADCREG_WAIT = 3'b100
   } adcreg_state_t;
endpackage

// file: rtl/adcreg_rate_gen.sv
`timescale 1ns/1ps
module adcreg_rate_gen (
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   // Control
   input wire logic [14:0] rate_in,
   // Sample tick
   output logic tick_out
);
   logic [15:0] period;
   logic [15:0] count;
   logic [1:0] pre;
   logic ref_tick;

   always_comb begin
      if (rate_in <= adcreg_pkg::RATE_FLOOR) begin
         period = adcreg_pkg::FIXED_DIV; // RULE2
      end else begin
         period = 16'({1'b0, rate_in} + 16'(adcreg_pkg::RATE_ADD)); // RULE3
      end
   end

   // Reference runs at half the bus clock; ticks stay one clock wide
   assign ref_tick = (pre == 2'(adcreg_pkg::REF_DIV - 1)); // RULE3

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pre <= 2'h0;
      end else if (clk_en_in) begin
         pre <= ref_tick ? 2'h0 : pre + 2'h1;
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         count <= 16'h0000;
         tick_out <= 1'b0;
      end else if (clk_en_in) begin
         if (!ref_tick) begin
            tick_out <= 1'b0;
         end else if (count >= period - 16'h0001) begin
            count <= 16'h0000;
            tick_out <= 1'b1;
         end else begin
            count <= count + 16'h0001;
            tick_out <= 1'b0;
         end
      end
   end
endmodule // adcreg_rate_gen

// file: rtl/adcreg_top.sv
// Operation
// RULE1 - Rate register holds bits 14..0; bit 15 reads zero.
// RULE2 - Settings up to 0x7A sample at fixed 100 kHz.
// RULE3 - Above that, period is reference clock over setting plus three.
// RULE4 - Three-bit level selects bus request line; zero disables.
// RULE5 - Level defaults zero; level and vector survive board reset.
// RULE6 - Vector byte is driven on data 7..0 during acknowledge; default zero.
// RULE7 - Any write to reset location resets board state.
// RULE8 - Board reset also starts an ADC calibration cycle.
// RULE9 - Trigger write starts scan when both trigger-mode bits clear.
// RULE10 - Gain bit 0 stores gain ten or unity for selected channel.
// RULE11 - Host selects channel, clears buffer field, then writes gain.
// RULE12 - Channel field is plain binary and indexes the gain entry.
// RULE13 - Byte and word accesses; unused bits read fixed, writes ignored.
`timescale 1ns/1ps
module adcreg_top (
   // Clock, reset, enable
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic clk_en_in,
   // Bus slave (synchronous to ref_clk_in)
   input wire logic sel_in,
   input wire logic write_in,
   input wire logic [7:0] addr_in,
   input wire logic [1:0] byte_en_in,
   input wire logic [15:0] wdata_in,
   input wire logic iack_in,
   output logic ack_out,
   output logic [15:0] rdata_out,
   // Control inputs from neighbouring registers
   input wire logic [5:0] chan_select_in,
   input wire logic [1:0] trig_mode_in,
   input wire logic auto_gain_in,
   input wire logic [5:0] scan_chan_in,
   // Block outputs
   output logic [2:0] irq_level_out,
   output logic board_reset_out,
   output logic cal_start_out,
   output logic scan_start_out,
   output logic sample_tick_out,
   output logic gain_ten_out
);
   ////////////////////////////////////////////////////////////////////
   logic [14:0] sample_rate_register;
   logic [2:0] irq_level_field;
   logic [7:0] vector_byte;
   logic gain_mem [adcreg_pkg::CHANNELS];
   logic [4:0] cal_count;
   logic tick;
   logic take;
   logic wr_hit;
   logic [15:0] next_rdata;
   adcreg_pkg::adcreg_state_t state;
   adcreg_pkg::adcreg_state_t next_state;

   ////////////////////////////////////////////////////////////////////
   // One-cycle ack, then wait for select to drop so one access acts once
   always_comb begin
      case (state)
         adcreg_pkg::ADCREG_IDLE: begin
            next_state = (sel_in || iack_in) ? adcreg_pkg::ADCREG_ACK
                                             : adcreg_pkg::ADCREG_IDLE;
         end
         adcreg_pkg::ADCREG_ACK: begin
            next_state = adcreg_pkg::ADCREG_WAIT;
         end
         adcreg_pkg::ADCREG_WAIT: begin
            next_state = (sel_in || iack_in) ? adcreg_pkg::ADCREG_WAIT
                                             : adcreg_pkg::ADCREG_IDLE;
         end
         default: begin
            next_state = adcreg_pkg::ADCREG_IDLE;
         end
      endcase
   end

   assign take = (state == adcreg_pkg::ADCREG_IDLE) && sel_in && !iack_in;
   assign wr_hit = take && write_in && (byte_en_in != 2'b00);

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= adcreg_pkg::ADCREG_IDLE;
         ack_out <= 1'b0;
      end else if (clk_en_in) begin
         state <= next_state;
         ack_out <= (state == adcreg_pkg::ADCREG_IDLE) && (sel_in || iack_in);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Rate register is cleared by a board reset; level and vector are not
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sample_rate_register <= adcreg_pkg::RATE_RST;
      end else if (clk_en_in) begin
         if (wr_hit && addr_in == adcreg_pkg::RESET_CMD_OFS) begin
            sample_rate_register <= adcreg_pkg::RATE_RST; // RULE7
         end else if (wr_hit && addr_in == adcreg_pkg::SAMPLE_RATE_OFS) begin
            if (byte_en_in[0]) begin
               sample_rate_register[7:0] <= wdata_in[7:0]; // RULE13
            end
            if (byte_en_in[1]) begin
               sample_rate_register[14:8] <= wdata_in[14:8]; // RULE1
            end
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_level_field <= adcreg_pkg::LEVEL_RST; // RULE5
         vector_byte <= adcreg_pkg::VECTOR_RST; // RULE6
      end else if (clk_en_in && wr_hit && byte_en_in[0]) begin
         if (addr_in == adcreg_pkg::IRQ_LEVEL_OFS) begin
            irq_level_field <= wdata_in[2:0]; // RULE4
         end
         if (addr_in == adcreg_pkg::VECTOR_OFS) begin
            vector_byte <= wdata_in[7:0];
         end
      end
   end

   // Gain store, no reset: contents survive both resets like a RAM
   always_ff @(posedge ref_clk_in) begin
      if (clk_en_in && wr_hit && byte_en_in[0] && addr_in == adcreg_pkg::GAIN_RAM_OFS) begin
         gain_mem[chan_select_in] <= wdata_in[adcreg_pkg::GAIN_BIT]; // RULE10 RULE12
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Command pulses and calibration
   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         board_reset_out <= 1'b0;
         scan_start_out <= 1'b0;
         cal_count <= 5'h00;
         cal_start_out <= 1'b0;
      end else if (clk_en_in) begin
         board_reset_out <= wr_hit && addr_in == adcreg_pkg::RESET_CMD_OFS; // RULE7
         scan_start_out <= wr_hit && addr_in == adcreg_pkg::TRIGGER_CMD_OFS
                           && trig_mode_in == 2'b00; // RULE9
         if (wr_hit && addr_in == adcreg_pkg::RESET_CMD_OFS) begin
            cal_count <= adcreg_pkg::CAL_LEN; // RULE8
            cal_start_out <= 1'b1;
         end else if (cal_count != 5'h00) begin
            cal_count <= cal_count - 5'h01;
            cal_start_out <= cal_count != 5'h01;
         end else begin
            cal_start_out <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read data, registered; acknowledge cycle returns the vector
   always_comb begin
      case (addr_in)
         adcreg_pkg::SAMPLE_RATE_OFS: next_rdata = {1'b0, sample_rate_register}; // RULE1
         adcreg_pkg::IRQ_LEVEL_OFS: next_rdata = adcreg_pkg::ONES_HIGH | {13'h0000, irq_level_field};
         adcreg_pkg::VECTOR_OFS: next_rdata = adcreg_pkg::ONES_HIGH | {8'h00, vector_byte};
         adcreg_pkg::GAIN_RAM_OFS: next_rdata = adcreg_pkg::ONES_HIGH
                                   | {15'h0000, gain_mem[chan_select_in]}; // RULE13
         default: next_rdata = adcreg_pkg::UNMAPPED_READ;
      endcase
      if (iack_in) begin
         next_rdata = adcreg_pkg::ONES_HIGH | {8'h00, vector_byte}; // RULE6
      end
   end

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= 16'h0000;
      end else if (clk_en_in && state == adcreg_pkg::ADCREG_IDLE
                   && (iack_in || (sel_in && !write_in))) begin
         rdata_out <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   adcreg_rate_gen u_rate (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .clk_en_in(clk_en_in),
      .rate_in(sample_rate_register),
      .tick_out(tick)
   );

   always_ff @(posedge ref_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sample_tick_out <= 1'b0;
         irq_level_out <= adcreg_pkg::LEVEL_RST;
         gain_ten_out <= 1'b0;
      end else if (clk_en_in) begin
         sample_tick_out <= tick; // RULE2 RULE3
         irq_level_out <= irq_level_field; // RULE4
         gain_ten_out <= auto_gain_in && gain_mem[scan_chan_in]; // RULE10
      end
   end
endmodule // adcreg_top

// file: tb/adcreg_top_assertions.sv
`timescale 1ns/1ps
module adcreg_top_assertions (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   // Bus
   input wire logic sel_in,
   input wire logic write_in,
   input wire logic [7:0] addr_in,
   input wire logic [1:0] trig_mode_in,
   input wire logic ack_out,
   // Block outputs
   input wire logic [2:0] irq_level_out,
   input wire logic board_reset_out,
   input wire logic cal_start_out,
   input wire logic scan_start_out,
   input wire logic sample_tick_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);
   a_ack_gap: assert property (ack_out |=> !ack_out [*2])
      else $error("ack not a lone pulse");
   a_reset_cause: assert property (board_reset_out |-> $past(sel_in && write_in)
      && $past(addr_in) == 8'h0C) else $error("board reset without command write");
   a_reset_cal: assert property (board_reset_out |-> ##[0:1] cal_start_out [*8])
      else $error("calibration not started by board reset");
   a_level_keep: assert property (board_reset_out |=> $stable(irq_level_out))
      else $error("level lost on board reset");
   a_level_write: assert property ($changed(irq_level_out) |-> $past(sel_in && write_in)
      && $past(addr_in) == 8'h08) else $error("level changed without write");
   a_scan_mode: assert property (scan_start_out |-> $past(trig_mode_in) == 2'b00
      && $past(addr_in) == 8'h0E) else $error("scan start without trigger");
   a_scan_pulse: assert property (scan_start_out |=> !scan_start_out)
      else $error("scan start too long");
   a_tick_gap: assert property ($rose(sample_tick_out) |=> !sample_tick_out [*8])
      else $error("sample ticks too close");
endmodule // adcreg_top_assertions
////////////////////////////////////////////////////////////////////////////////
bind adcreg_top adcreg_top_assertions adcreg_top_assertions_inst (.ref_clk_in(ref_clk_in),
   .nrst_in(nrst_in), .sel_in(sel_in), .write_in(write_in), .addr_in(addr_in),
   .trig_mode_in(trig_mode_in), .ack_out(ack_out), .irq_level_out(irq_level_out),
   .board_reset_out(board_reset_out), .cal_start_out(cal_start_out),
   .scan_start_out(scan_start_out), .sample_tick_out(sample_tick_out));

// file: tb/adcreg_host_model.sv
`timescale 1ns/1ps
module adcreg_host_model (
   // Clock and answer
   input wire logic ref_clk_in,
   input wire logic ack_in,
   // Bus request
   output logic sel_out,
   output logic write_out,
   output logic iack_out,
   output logic [7:0] addr_out,
   output logic [1:0] byte_en_out,
   output logic [15:0] wdata_out,
   output logic hung_out
);
   int gap = 0;
   initial {sel_out, write_out, iack_out, hung_out, addr_out, byte_en_out, wdata_out} = '0;
   // Held until ack is sampled; released address and data lines show inverted values, never stale
   task automatic xfer(input logic w, input logic [7:0] a, input logic [1:0] be,
      input logic [15:0] d, input logic ia);
      int n;
      n = 0;
      repeat (gap + 1) @(posedge ref_clk_in);
      #1 {sel_out, iack_out, write_out, addr_out, byte_en_out, wdata_out} = {!ia, ia, w, a, be, d};
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (!ack_in && n < 20);
      hung_out = !ack_in;
      #1 {sel_out, iack_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
   endtask
endmodule // adcreg_host_model

// file: tb/adcreg_top_tb.sv
`timescale 1ns/1ps
module adcreg_top_tb;
   logic ref_clk_in = 0, nrst_in = 0, auto_gain_in = 0, sel_in, write_in, iack_in, hung;
   logic clk_en_in = 1;
   int tick_n = 0;
   logic ack_out, board_reset_out, cal_start_out, scan_start_out, sample_tick_out, gain_ten_out;
   logic [1:0] byte_en_in, trig_mode_in = 2'h0;
   logic [2:0] irq_level_out;
   logic [5:0] chan_select_in = 6'h00, scan_chan_in = 6'h00;
   logic [5:0] chs[3] = '{6'h00, 6'h01, 6'h3F};
   logic [7:0] addr_in, vb;
   logic [15:0] rdata_out, wdata_in, v, q[$];
   int fail_count = 0, cmp_count = 0, scan_n = 0, brst_n = 0, cal_n = 0, seed = 32'hED85D3E1;
   always #20 ref_clk_in = ~ref_clk_in;
   adcreg_top adcreg_top_inst (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .clk_en_in(clk_en_in),
      .sel_in(sel_in), .write_in(write_in), .addr_in(addr_in), .byte_en_in(byte_en_in),
      .wdata_in(wdata_in), .iack_in(iack_in), .ack_out(ack_out), .rdata_out(rdata_out),
      .chan_select_in(chan_select_in), .trig_mode_in(trig_mode_in), .auto_gain_in(auto_gain_in),
      .scan_chan_in(scan_chan_in), .irq_level_out(irq_level_out),
      .board_reset_out(board_reset_out), .cal_start_out(cal_start_out),
      .scan_start_out(scan_start_out), .sample_tick_out(sample_tick_out),
      .gain_ten_out(gain_ten_out));
   adcreg_host_model adcreg_host_model_inst (.ref_clk_in(ref_clk_in), .ack_in(ack_out),
      .sel_out(sel_in), .write_out(write_in), .iack_out(iack_in), .addr_out(addr_in),
      .byte_en_out(byte_en_in), .wdata_out(wdata_in), .hung_out(hung));
   task chk(input logic [15:0] e, input logic [15:0] a);
      cmp_count++;
      if (a !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
      end
   endtask
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be = 2'b11);
      adcreg_host_model_inst.xfer(1'b1, a, be, d, 1'b0);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e, input logic ia = 1'b0);
      q.push_back(e);
      adcreg_host_model_inst.xfer(1'b0, a, 2'b11, 16'h0000, ia);
   endtask
   // Edges between two ticks; the first gap may straddle the rate write
   task per(input int e);
      int n;
      n = 0;
      do @(posedge ref_clk_in); while (!sample_tick_out && ++n < 600);
      n = 0;
      do begin
         @(posedge ref_clk_in);
         n++;
      end while (!sample_tick_out && n < 600);
      chk(16'(e), 16'(n));
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge hung) begin
      fail_count++;
      stop_test();
   end
   always @(posedge ref_clk_in) begin
      if (ack_out && !write_in) chk(q.pop_front(), rdata_out);
      if (scan_start_out) scan_n++;
      if (board_reset_out) brst_n++;
      if (cal_start_out) cal_n++;
      if (sample_tick_out) tick_n++;
   end
   initial begin
      repeat (3) @(posedge ref_clk_in);
      #1 nrst_in = 1;
      rd(8'h06, 16'h0000);
      rd(8'h08, 16'hFF00);
      rd(8'h0A, 16'hFF00, 1'b1);
      rd(8'h02, 16'hFFFF);
      wr(8'h06, 16'hFFFF);
      rd(8'h06, 16'h7FFF);
      wr(8'h06, 16'h12AA, 2'b01);
      rd(8'h06, 16'h7FAA);
      for (int i = 0; i < 8; i++) begin
         v = 16'($random(seed));
         wr(8'h08, {v[15:3], 3'(i)});
         chk(16'(i), {13'h0000, irq_level_out});
         rd(8'h08, 16'hFF00 | 16'(i));
      end
      vb = 8'($random(seed));
      wr(8'h0A, {8'h5A, vb});
      rd(8'h0A, {8'hFF, vb}, 1'b1);
      wr(8'h06, 16'h007A);
      per(250);
      wr(8'h06, 16'h007B);
      per(252);
      // Clock enable low must freeze the sample timer
      #1 clk_en_in = 0;
      v = 16'(tick_n);
      repeat (300) @(posedge ref_clk_in);
      #1 clk_en_in = 1;
      chk(v, 16'(tick_n));
      for (int m = 0; m < 4; m++) begin
         trig_mode_in = 2'(m);
         v = 16'(scan_n);
         wr(8'h0E, 16'($random(seed)));
         repeat (2) @(posedge ref_clk_in);
         #1 chk(v + 16'(m == 0), 16'(scan_n));
      end
      v = 16'(brst_n);
      cal_n = 0;
      wr(8'h0C, 16'($random(seed)));
      repeat (20) @(posedge ref_clk_in);
      #1 chk(v + 16'h0001, 16'(brst_n));
      chk(16'h0010, 16'(cal_n));
      rd(8'h06, 16'h0000);
      rd(8'h08, 16'hFF07);
      rd(8'h0A, {8'hFF, vb}, 1'b1);
      adcreg_host_model_inst.gap = 2;
      for (int c = 0; c < 3; c++) begin
         chan_select_in = chs[c];
         wr(8'h10, {15'h2A55, 1'(c != 1)});
      end
      for (int c = 0; c < 4; c++) begin
         auto_gain_in = 1'(c < 3);
         chan_select_in = chs[c % 3];
         scan_chan_in = chs[c % 3];
         rd(8'h10, {15'h7F80, 1'(c % 3 != 1)});
         #1 chk(16'(c == 0 || c == 2), 16'(gain_ten_out));
      end
      @(posedge ref_clk_in);
      #1 nrst_in = 0;
      repeat (2) @(posedge ref_clk_in);
      #1 nrst_in = 1;
      rd(8'h08, 16'hFF00);
      stop_test();
   end
endmodule // adcreg_top_tb
